/* File: inc/mseq_defines.vh */
// Purpose: Constants for the measurement sequencer: timing, encodings, status codes.
// Assumes: mclk runs at 20 MHz; all times are typical figures in microseconds.
// Notes:   Cycle counts are derived from the times with MSEQ_US2CYC.
`ifndef MSEQ_DEFINES_VH
`define MSEQ_DEFINES_VH

// ----------------------------------------------------------------------------
// Clock and derivation
// ----------------------------------------------------------------------------
`define MSEQ_MCLK_MHZ        20
`define MSEQ_US2CYC(us)      ((us) * `MSEQ_MCLK_MHZ)
`define MSEQ_SLOW_NUM        11
`define MSEQ_SLOW_DEN        10

// ----------------------------------------------------------------------------
// Typical times in microseconds
// ----------------------------------------------------------------------------
`define MSEQ_T_WIN_SHORT_US  3000
`define MSEQ_T_WIN_LONG_US   10000
`define MSEQ_T_WAKE_US       100
`define MSEQ_T_CONV8_US      300
`define MSEQ_T_CONV10_US     1150
`define MSEQ_T_CONV12_US     4500
`define MSEQ_T_CONV14_US     18000
`define MSEQ_T_TCALC_US      250
`define MSEQ_T_CCALC_US      300
`define MSEQ_T_PD5_US        5000
`define MSEQ_T_PD25_US       25000
`define MSEQ_T_PD125_US      125000

// ----------------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------------
`define MSEQ_RES_8           2'h0
`define MSEQ_RES_10          2'h1
`define MSEQ_RES_12          2'h2
`define MSEQ_RES_14          2'h3
`define MSEQ_RATE_0          2'h0
`define MSEQ_RATE_5          2'h1
`define MSEQ_RATE_25         2'h2
`define MSEQ_RATE_125        2'h3
`define MSEQ_ST_VALID        2'h0
`define MSEQ_ST_STALE        2'h1
`define MSEQ_ST_CMDMODE      2'h2
`define MSEQ_TEMP_PERIOD     3'h6
`define MSEQ_DATA_W          14
`define MSEQ_CNT_W           22

`endif

/* File: rtl/mseq_result_mem.v */
// Purpose: Two-bank result store; one bank is published while the other is written.
// Assumes: Single clock; one write and one read port.
// Notes:   Read data come out of a register, one cycle after the address.
`timescale 1ns/1ns

module mseq_result_mem (
    input  wire        mclk,
    input  wire        rst,
    input  wire        wrEn,
    input  wire        wrAddr,
    input  wire [27:0] wrData,
    input  wire        rdAddr,
    output reg  [27:0] rdData_q
);

    reg [27:0] mem [0:1];

    always @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdData_q <= 28'h0000000;
        end else begin
            rdData_q <= mem[rdAddr];
        end
    end

endmodule

/* File: rtl/mseq_sequencer.v */
// Purpose: Power-on command window, mode choice and measurement cycle sequencing.
// Assumes: Commands and configuration come from logic on mclk; config is static.
// Notes:   Converter and correction math live outside; their results are sampled here.
`timescale 1ns/1ns
`include "mseq_defines.vh"

// Behaviour
// RULE_01: Answer as I2C slave after power-on reset.
// RULE_02: Command window lasts 3 ms short, else 10 ms.
// RULE_03: Enter-command in window enters command mode until start-normal.
// RULE_04: Window expiry or start-normal runs one cycle.
// RULE_05: First result written at initial capacitance correction end.
// RULE_06: Cycle is wakeup, temperature, then capacitance steps.
// RULE_07: Two-bit resolution field selects 8/10/12/14 bits.
// RULE_08: Conversion times 0.30, 1.15, 4.50, 18.0 ms.
// RULE_09: Each conversion followed by its correction calculation.
// RULE_10: Mode bit selects periodic update or on-request sleep.
// RULE_11: Update mode publishes results, powers down, repeats.
// RULE_12: Power-down interval 0, 5, 25 or 125 ms.
// RULE_13: Fastest rate skips power-down, cycles back to back.
// RULE_14: Update mode measures temperature once per six.
// RULE_15: 12-bit temperature step takes 4.5 plus 0.25 ms.
// RULE_16: Update mode serves every output option.
// RULE_17: Worst-case durations up to 1.1 times typical.
// RULE_18: Sleep mode converts only on measurement request.
// RULE_19: Status 00 valid, 01 stale, 10 command mode.
// RULE_20: Early fetch returns previous result marked stale.
// RULE_21: Durations counted in clocks; temperature counter restarts.
// RULE_22: Five capacitance-only cycles between temperature cycles.
module mseq_sequencer #(
    parameter integer WIN_SHORT_CYC = `MSEQ_US2CYC(`MSEQ_T_WIN_SHORT_US),
    parameter integer WIN_LONG_CYC  = `MSEQ_US2CYC(`MSEQ_T_WIN_LONG_US),
    parameter integer CONV8_CYC     = `MSEQ_US2CYC(`MSEQ_T_CONV8_US),
    parameter integer CONV10_CYC    = `MSEQ_US2CYC(`MSEQ_T_CONV10_US),
    parameter integer CONV12_CYC    = `MSEQ_US2CYC(`MSEQ_T_CONV12_US),
    parameter integer CONV14_CYC    = `MSEQ_US2CYC(`MSEQ_T_CONV14_US),
    parameter integer TCALC_CYC     = `MSEQ_US2CYC(`MSEQ_T_TCALC_US),
    parameter integer CCALC_CYC     = `MSEQ_US2CYC(`MSEQ_T_CCALC_US),
    parameter integer PD5_CYC       = `MSEQ_US2CYC(`MSEQ_T_PD5_US),
    parameter integer PD25_CYC      = `MSEQ_US2CYC(`MSEQ_T_PD25_US),
    parameter integer PD125_CYC     = `MSEQ_US2CYC(`MSEQ_T_PD125_US),
    parameter integer SLOW_OSC      = 0
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        shortWindowCfg,
    input  wire        updateModeCfg,
    input  wire [1:0]  updateRateCfg,
    input  wire [1:0]  capResCfg,
    input  wire [1:0]  tempResCfg,
    input  wire        spiOutputCfg,
    input  wire        enterCommandModeCmd,
    input  wire        startNormalOperationCmd,
    input  wire        measurementRequestCmd,
    input  wire        dataFetchCmd,
    input  wire [13:0] tempCorrIn,
    input  wire [13:0] capCorrIn,
    output reg         i2cMode_q,
    output reg         cmdMode_q,
    output reg         powerDown_q,
    output reg         tempConv_q,
    output reg         tempCalc_q,
    output reg         capConv_q,
    output reg         capCalc_q,
    output reg         outputUpdate_q,
    output reg         dataReady_q,
    output reg         fetchValid_q,
    output reg  [15:0] fetchWord_q,
    output reg  [13:0] fetchTemp_q
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [9:0] ST_BOOT  = 10'h001;
    localparam [9:0] ST_WIN   = 10'h002;
    localparam [9:0] ST_CMD   = 10'h004;
    localparam [9:0] ST_WAKE  = 10'h008;
    localparam [9:0] ST_TCONV = 10'h010;
    localparam [9:0] ST_TCALC = 10'h020;
    localparam [9:0] ST_CCONV = 10'h040;
    localparam [9:0] ST_CCALC = 10'h080;
    localparam [9:0] ST_PDOWN = 10'h100;
    localparam [9:0] ST_SLEEP = 10'h200;

    localparam integer WAKE_CYC = `MSEQ_US2CYC(`MSEQ_T_WAKE_US);

    // ------------------------------------------------------------------------
    // Duration helpers
    // ------------------------------------------------------------------------
    // Converts a typical count into a down-counter load value. The slow
    // oscillator option stretches it to the worst case for margin studies.
    function [21:0] loadOf;
        input [31:0] cyc;
        reg   [31:0] s;
        begin
            s = (SLOW_OSC != 0) ? (cyc * `MSEQ_SLOW_NUM) / `MSEQ_SLOW_DEN : cyc; // RULE_17
            if (s == 32'h00000000) begin
                s = 32'h00000001;
            end
            loadOf = s[21:0] - 22'h000001;
        end
    endfunction

    function [31:0] convCyc;
        input [1:0] res;
        begin
            case (res) // RULE_07
                `MSEQ_RES_8:  convCyc = CONV8_CYC; // RULE_08
                `MSEQ_RES_10: convCyc = CONV10_CYC;
                `MSEQ_RES_12: convCyc = CONV12_CYC;
                default:      convCyc = CONV14_CYC;
            endcase
        end
    endfunction

    function [31:0] pdCyc;
        input [1:0] rate;
        begin
            case (rate) // RULE_12
                `MSEQ_RATE_5:  pdCyc = PD5_CYC;
                `MSEQ_RATE_25: pdCyc = PD25_CYC;
                default:       pdCyc = PD125_CYC;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [9:0]  state_q;
    reg  [9:0]  state_d;
    reg  [21:0] cnt_q;
    reg  [21:0] cnt_d;
    reg  [2:0]  cycleIdx_q;
    reg  [2:0]  cycleIdx_d;
    reg         normalOp_q;
    reg         enterNormal;
    reg  [13:0] tempHold_q;
    reg         bank_q;
    reg         publish_q;
    reg         memWe;
    reg         anyPub_q;
    reg  [1:0]  status;
    wire        cntDone;
    wire        tempDue;
    wire [27:0] memRdData;

    assign cntDone = (cnt_q == 22'h000000);
    // Sleep-mode cycles always include temperature; update mode runs it on slot zero.
    assign tempDue = !updateModeCfg || (cycleIdx_q == 3'h0); // RULE_14

    // ------------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------------
    always @* begin
        state_d     = state_q;
        cnt_d       = cntDone ? cnt_q : cnt_q - 22'h000001; // RULE_21
        cycleIdx_d  = cycleIdx_q;
        enterNormal = 1'b0;
        memWe       = 1'b0;
        case (state_q)
            ST_BOOT: begin
                state_d = ST_WIN;
                cnt_d   = loadOf(shortWindowCfg ? WIN_SHORT_CYC : WIN_LONG_CYC); // RULE_02
            end
            ST_WIN: begin
                if (enterCommandModeCmd) begin
                    state_d = ST_CMD; // RULE_03
                end else if (cntDone) begin
                    enterNormal = 1'b1; // RULE_04
                end
            end
            ST_CMD: begin
                // Only start-normal leaves command mode; other commands are ignored.
                if (startNormalOperationCmd) begin
                    enterNormal = 1'b1; // RULE_04
                end
            end
            ST_WAKE: begin
                if (cntDone) begin
                    if (tempDue) begin
                        state_d = ST_TCONV; // RULE_06
                        cnt_d   = loadOf(convCyc(tempResCfg));
                    end else begin
                        state_d = ST_CCONV;
                        cnt_d   = loadOf(convCyc(capResCfg));
                    end
                end
            end
            ST_TCONV: begin
                if (cntDone) begin
                    state_d = ST_TCALC; // RULE_09
                    cnt_d   = loadOf(TCALC_CYC); // RULE_15
                end
            end
            ST_TCALC: begin
                if (cntDone) begin
                    state_d = ST_CCONV; // RULE_14
                    cnt_d   = loadOf(convCyc(capResCfg));
                end
            end
            ST_CCONV: begin
                if (cntDone) begin
                    state_d = ST_CCALC; // RULE_09
                    cnt_d   = loadOf(CCALC_CYC);
                end
            end
            ST_CCALC: begin
                if (cntDone) begin
                    memWe = 1'b1; // RULE_05
                    if (updateModeCfg) begin // RULE_10
                        cycleIdx_d = (cycleIdx_q == `MSEQ_TEMP_PERIOD - 3'h1) ?
                                     3'h0 : cycleIdx_q + 3'h1; // RULE_22
                        if (updateRateCfg == `MSEQ_RATE_0) begin
                            state_d = ST_WAKE; // RULE_13
                            cnt_d   = loadOf(WAKE_CYC);
                        end else begin
                            state_d = ST_PDOWN; // RULE_11
                            cnt_d   = loadOf(pdCyc(updateRateCfg));
                        end
                    end else begin
                        state_d = ST_SLEEP; // RULE_18
                    end
                end
            end
            ST_PDOWN: begin
                if (cntDone) begin
                    state_d = ST_WAKE; // RULE_11
                    cnt_d   = loadOf(WAKE_CYC);
                end
            end
            ST_SLEEP: begin
                if (measurementRequestCmd) begin
                    state_d = ST_WAKE; // RULE_18
                    cnt_d   = loadOf(WAKE_CYC);
                end
            end
            default: begin
                state_d = ST_BOOT;
            end
        endcase
        if (enterNormal) begin
            // Every entry to normal operation starts with a full cycle.
            state_d    = ST_WAKE; // RULE_06
            cnt_d      = loadOf(WAKE_CYC);
            cycleIdx_d = 3'h0; // RULE_21
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q    <= ST_BOOT;
            cnt_q      <= 22'h000000;
            cycleIdx_q <= 3'h0;
            normalOp_q <= 1'b0;
            tempHold_q <= 14'h0000;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            cycleIdx_q <= cycleIdx_d;
            if (enterNormal) begin
                normalOp_q <= 1'b1;
            end
            if ((state_q == ST_TCALC) && cntDone) begin
                tempHold_q <= tempCorrIn; // RULE_09
            end
        end
    end

    // ------------------------------------------------------------------------
    // Result publication
    // ------------------------------------------------------------------------
    // Writing the idle bank and then flipping keeps a fetch from ever seeing a pair mixed from two writes;
    // capacitance-only cycles store the new capacitance with the temperature held from an earlier cycle.
    mseq_result_mem uMem (
        .mclk     (mclk),
        .rst      (rst),
        .wrEn     (memWe),
        .wrAddr   (~bank_q),
        .wrData   ({tempHold_q, capCorrIn}),
        .rdAddr   (bank_q),
        .rdData_q (memRdData)
    );

    always @* begin
        if (cmdMode_q) begin
            status = `MSEQ_ST_CMDMODE; // RULE_19
        end else if (dataReady_q) begin
            status = `MSEQ_ST_VALID;
        end else begin
            status = `MSEQ_ST_STALE; // RULE_20
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            bank_q         <= 1'b0;
            anyPub_q       <= 1'b0;
            publish_q      <= 1'b0;
            outputUpdate_q <= 1'b0;
            dataReady_q    <= 1'b0;
            fetchValid_q   <= 1'b0;
            fetchWord_q    <= 16'h0000;
            fetchTemp_q    <= 14'h0000;
        end else begin
            publish_q      <= memWe;
            // The result store is not cleared by reset, so it is masked until a first result.
            anyPub_q       <= anyPub_q | publish_q; // RULE_20
            outputUpdate_q <= publish_q; // RULE_16
            if (memWe) begin
                bank_q <= ~bank_q; // RULE_11
            end
            // A new result arriving with a fetch wins, so it is never reported stale.
            if (publish_q) begin
                dataReady_q <= 1'b1; // RULE_19
            end else if (dataFetchCmd) begin
                dataReady_q <= 1'b0; // RULE_20
            end
            fetchValid_q <= dataFetchCmd;
            if (dataFetchCmd) begin
                fetchWord_q <= {status, anyPub_q ? memRdData[13:0] : 14'h0000}; // RULE_19
                fetchTemp_q <= anyPub_q ? memRdData[27:14] : 14'h0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode and phase outputs
    // ------------------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            i2cMode_q   <= 1'b1;
            cmdMode_q   <= 1'b0;
            powerDown_q <= 1'b0;
            tempConv_q  <= 1'b0;
            tempCalc_q  <= 1'b0;
            capConv_q   <= 1'b0;
            capCalc_q   <= 1'b0;
        end else begin
            // The programmed protocol applies only once normal operation starts.
            i2cMode_q   <= (normalOp_q || enterNormal) ? !spiOutputCfg : 1'b1; // RULE_01
            cmdMode_q   <= (state_d == ST_CMD); // RULE_03
            powerDown_q <= (state_d == ST_PDOWN) || (state_d == ST_SLEEP); // RULE_18
            tempConv_q  <= (state_d == ST_TCONV);
            tempCalc_q  <= (state_d == ST_TCALC);
            capConv_q   <= (state_d == ST_CCONV);
            capCalc_q   <= (state_d == ST_CCALC);
        end
    end

endmodule

/* File: tb/mseq_host_model.sv */
// Purpose: Host model issuing command pulses.
// Assumes: One pulse at a time.
// Notes:   Strobes change on rising edges only.
`timescale 1ns/1ns
module mseq_host_model (
    input  wire mclk,
    output reg  enterCommandModeCmd,
    output reg  startNormalOperationCmd,
    output reg  measurementRequestCmd,
    output reg  dataFetchCmd
);
    initial begin
        {enterCommandModeCmd, startNormalOperationCmd, measurementRequestCmd, dataFetchCmd} = 4'h0;
    end

    // Codes are 0 enter command mode, 1 start normal, 2 measure request, 3 fetch.
    task send(input [1:0] code);
        begin
            @(posedge mclk);
            {enterCommandModeCmd, startNormalOperationCmd, measurementRequestCmd,
             dataFetchCmd} <= 4'h8 >> code;
            @(posedge mclk);
            {enterCommandModeCmd, startNormalOperationCmd, measurementRequestCmd,
             dataFetchCmd} <= 4'h0;
        end
    endtask
endmodule

/* File: tb/mseq_sequencer_asserts.sv */
// Purpose: Port-level assertions.
// Assumes: Nominal oscillator.
// Notes:   Long phases are timed with counters.
`timescale 1ns/1ns
module mseq_sequencer_asserts #(
    parameter integer CONV8_CYC  = 10,
    parameter integer CONV10_CYC = 20,
    parameter integer CONV12_CYC = 30,
    parameter integer CONV14_CYC = 40,
    parameter integer PD5_CYC    = 20,
    parameter integer PD25_CYC   = 50,
    parameter integer PD125_CYC  = 100
) (
    input wire        mclk,
    input wire        rst,
    input wire        updateModeCfg,
    input wire [1:0]  updateRateCfg,
    input wire [1:0]  capResCfg,
    input wire [1:0]  tempResCfg,
    input wire        spiOutputCfg,
    input wire        enterCommandModeCmd,
    input wire        startNormalOperationCmd,
    input wire        dataFetchCmd,
    input wire        i2cMode_q,
    input wire        cmdMode_q,
    input wire        powerDown_q,
    input wire        tempConv_q,
    input wire        tempCalc_q,
    input wire        capConv_q,
    input wire        capCalc_q,
    input wire        outputUpdate_q,
    input wire        dataReady_q,
    input wire        fetchValid_q,
    input wire [15:0] fetchWord_q
);
    reg [31:0] tcCnt_q;
    reg [31:0] ccCnt_q;
    reg [31:0] pdCnt_q;
    reg [3:0]  capSeen_q;

    function integer convLen(input [1:0] r);
        convLen = (r == 2'h0) ? CONV8_CYC : (r == 2'h1) ? CONV10_CYC :
                  (r == 2'h2) ? CONV12_CYC : CONV14_CYC;
    endfunction

    function integer pdLen(input [1:0] r);
        pdLen = (r == 2'h1) ? PD5_CYC : (r == 2'h2) ? PD25_CYC : PD125_CYC;
    endfunction

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tcCnt_q   <= 32'h0;
            ccCnt_q   <= 32'h0;
            pdCnt_q   <= 32'h0;
            capSeen_q <= 4'h0;
        end else begin
            tcCnt_q <= tempConv_q ? tcCnt_q + 32'h1 : 32'h0;
            ccCnt_q <= capConv_q ? ccCnt_q + 32'h1 : 32'h0;
            pdCnt_q <= powerDown_q ? pdCnt_q + 32'h1 : 32'h0;
            if (tempConv_q && tcCnt_q == 32'h0) begin
                capSeen_q <= 4'h0;
            end else if (capConv_q && ccCnt_q == 32'h0 && capSeen_q != 4'hF) begin
                capSeen_q <= capSeen_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence sTempConvEnd;
        $fell(tempConv_q);
    endsequence
    sequence sCapCalcEnd;
        $fell(capCalc_q);
    endsequence

    AST_RESET_I2C: assert property ($past(rst) || cmdMode_q |-> i2cMode_q)
        else $error("i2c mode");
    AST_CMD_ENTER: assert property ($rose(cmdMode_q) |-> $past(enterCommandModeCmd))
        else $error("cmd entry");
    AST_CMD_STAY: assert property (cmdMode_q && !startNormalOperationCmd |=> cmdMode_q)
        else $error("cmd left");
    AST_OUT_MODE: assert property (tempConv_q || capConv_q |-> i2cMode_q == !spiOutputCfg)
        else $error("protocol");
    AST_TCONV_LEN: assert property (sTempConvEnd |-> tcCnt_q == convLen(tempResCfg))
        else $error("tconv len");
    AST_CCONV_LEN: assert property ($fell(capConv_q) |-> ccCnt_q == convLen(capResCfg))
        else $error("cconv len");
    AST_STEP_ORDER: assert property (sTempConvEnd |-> tempCalc_q)
        else $error("no calc");
    AST_PUBLISH: assert property (sCapCalcEnd |-> ##[0:3] outputUpdate_q && dataReady_q)
        else $error("no publish");
    AST_FETCH_ANS: assert property (dataFetchCmd |=> fetchValid_q)
        else $error("no fetch");
    AST_CMD_STATUS: assert property (fetchValid_q && cmdMode_q |-> fetchWord_q[15:14] == 2'h2)
        else $error("cmd status");
    AST_PD_LEN: assert property ($fell(powerDown_q) && updateModeCfg && capSeen_q != 4'h0
        |-> pdCnt_q == pdLen(updateRateCfg)) else $error("pd len");
    AST_NO_PD: assert property (updateModeCfg && updateRateCfg == 2'h0 && capSeen_q != 4'h0
        |-> !powerDown_q) else $error("pd at rate 0");
    AST_UPD_PD: assert property ($fell(capCalc_q) && updateModeCfg && updateRateCfg != 2'h0
        |-> ##[1:16] powerDown_q) else $error("no pd");
    AST_SIX: assert property ($rose(tempConv_q) && updateModeCfg && capSeen_q != 4'h0
        |-> capSeen_q == 4'h6) else $error("temp period");
endmodule

/* File: tb/mseq_sequencer_tb_top.sv */
// Purpose: Self-checking bench.
// Assumes: Shortened counts.
// Notes:   The model publishes on outputUpdate_q.
`timescale 1ns/1ns
module mseq_sequencer_tb_top;
    localparam integer WIN_S = 60;
    localparam integer CEIL  = 95000;
    reg         mclk;
    reg         rst;
    reg         shortWindowCfg;
    reg         updateModeCfg;
    reg  [1:0]  updateRateCfg;
    reg  [1:0]  capResCfg;
    reg  [1:0]  tempResCfg;
    reg         spiOutputCfg;
    reg  [13:0] tempCorrIn;
    reg  [13:0] capCorrIn;
    wire        enterCmd;
    wire        startCmd;
    wire        measCmd;
    wire        fetchCmd;
    wire        i2cMode_q;
    wire        cmdMode_q;
    wire        powerDown_q;
    wire        tempConv_q;
    wire        outputUpdate_q;
    wire        dataReady_q;
    wire        fetchValid_q;
    wire [15:0] fetchWord_q;
    wire [13:0] fetchTemp_q;
    reg  [13:0] pubCap;
    reg  [13:0] pubTemp;
    reg         fetched;
    reg         inCmd;
    reg         tempSeen;
    integer     pubCount;
    integer     cycles;
    integer     mismatches;
    integer     comparisons;
    integer     i;
    integer     t0;

    mseq_host_model u_host (.mclk(mclk), .enterCommandModeCmd(enterCmd),
        .startNormalOperationCmd(startCmd), .measurementRequestCmd(measCmd),
        .dataFetchCmd(fetchCmd));

    mseq_sequencer #(.WIN_SHORT_CYC(WIN_S), .WIN_LONG_CYC(200), .CONV8_CYC(10),
        .CONV10_CYC(20), .CONV12_CYC(30), .CONV14_CYC(40), .TCALC_CYC(5), .CCALC_CYC(6),
        .PD5_CYC(20), .PD25_CYC(50), .PD125_CYC(100)) u_dut (.mclk(mclk), .rst(rst),
        .shortWindowCfg(shortWindowCfg), .updateModeCfg(updateModeCfg),
        .updateRateCfg(updateRateCfg), .capResCfg(capResCfg), .tempResCfg(tempResCfg),
        .spiOutputCfg(spiOutputCfg), .enterCommandModeCmd(enterCmd),
        .startNormalOperationCmd(startCmd), .measurementRequestCmd(measCmd),
        .dataFetchCmd(fetchCmd), .tempCorrIn(tempCorrIn), .capCorrIn(capCorrIn),
        .i2cMode_q(i2cMode_q), .cmdMode_q(cmdMode_q), .powerDown_q(powerDown_q),
        .tempConv_q(tempConv_q), .tempCalc_q(), .capConv_q(), .capCalc_q(),
        .outputUpdate_q(outputUpdate_q), .dataReady_q(dataReady_q),
        .fetchValid_q(fetchValid_q), .fetchWord_q(fetchWord_q), .fetchTemp_q(fetchTemp_q));

    task chkBit(input a, input e);
        begin
            chkWord({15'h0000, a}, {15'h0000, e});
        end
    endtask

    task chkWord(input [15:0] a, input [15:0] e);
        begin
            comparisons = comparisons + 1;
            if (a !== e) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: got %h expected %h", $time, a, e);
            end
        end
    endtask

    task stop_test;
        begin
            if (mismatches == 0 && comparisons > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask

    task restart(input s, input u, input [1:0] r, input p, input [1:0] res);
        begin
            @(posedge mclk);
            rst <= 1'b1;
            {shortWindowCfg, updateModeCfg, updateRateCfg, spiOutputCfg} <= {s, u, r, p};
            {capResCfg, tempResCfg} <= {res, ~res};
            repeat (5) @(posedge mclk);
            rst <= 1'b0;
            {pubCap, pubTemp, fetched, inCmd, tempSeen} = 31'h00000004;
            @(posedge mclk);
            #1;
            chkBit(i2cMode_q, 1'b1);
        end
    endtask

    task waitPub;
        integer n;
        begin
            n = pubCount;
            t0 = cycles;
            while (pubCount == n && cycles - t0 < 8000) begin
                @(posedge mclk);
                #1;
            end
            chkBit(pubCount != n, 1'b1);
            chkBit(dataReady_q, 1'b1);
        end
    endtask

    task doFetch;
        reg [15:0] expWord;
        begin
            expWord = {inCmd ? 2'h2 : (fetched ? 2'h1 : 2'h0), pubCap};
            u_host.send(2'h3);
            #1;
            chkBit(fetchValid_q, 1'b1);
            chkWord(fetchWord_q, expWord);
            chkWord({2'h0, fetchTemp_q}, {2'h0, pubTemp});
            chkBit(dataReady_q, 1'b0);
            fetched = 1'b1;
        end
    endtask

    // A temperature result reaches the output only in cycles that measured it.
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (tempConv_q === 1'b1) begin
            tempSeen <= 1'b1;
        end
        if (outputUpdate_q === 1'b1) begin
            pubCap <= capCorrIn;
            pubTemp <= tempSeen ? tempCorrIn : pubTemp;
            tempSeen <= 1'b0;
            fetched <= 1'b0;
            pubCount <= pubCount + 1;
            capCorrIn <= 14'($urandom);
            tempCorrIn <= 14'($urandom);
        end
        if (cycles == CEIL) begin
            mismatches = mismatches + 1;
            stop_test;
        end
    end

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        pubCount = 0;
        rst = 1'b1;
        i = $urandom(32'h2DEC89FB);
        capCorrIn = 14'($urandom);
        tempCorrIn = 14'($urandom);
        restart(i[0], 1'b0, 2'h0, 1'b1, 2'h2);
        t0 = cycles;
        doFetch;
        while (i2cMode_q === 1'b1 && cycles - t0 < 1000) begin
            @(posedge mclk);
            #1;
        end
        i = cycles - t0 - (shortWindowCfg ? WIN_S : 200);
        chkBit(i >= -2 && i <= 3, 1'b1);
        u_host.send(2'h0);
        #1;
        chkBit(cmdMode_q, 1'b0);
        waitPub;
        doFetch;
        doFetch;
        repeat (500) @(posedge mclk);
        #1;
        chkBit(tempSeen, 1'b0);
        chkBit(powerDown_q, 1'b1);
        u_host.send(2'h2);
        waitPub;
        doFetch;
        for (i = 0; i < 4; i = i + 1) begin
            restart(1'b0, 1'b1, i[1:0], capCorrIn[0], i[1:0]);
            repeat (100) @(posedge mclk);
            #1;
            chkBit(i2cMode_q, 1'b1);
            u_host.send(2'h0);
            inCmd = 1'b1;
            #1;
            chkBit(cmdMode_q, 1'b1);
            repeat (300) @(posedge mclk);
            doFetch;
            u_host.send(2'h1);
            inCmd = 1'b0;
            repeat (7) begin
                waitPub;
                doFetch;
            end
        end
        stop_test;
    end
endmodule

bind mseq_sequencer mseq_sequencer_asserts #(.CONV8_CYC(CONV8_CYC), .CONV10_CYC(CONV10_CYC),
    .CONV12_CYC(CONV12_CYC), .CONV14_CYC(CONV14_CYC), .PD5_CYC(PD5_CYC), .PD25_CYC(PD25_CYC),
    .PD125_CYC(PD125_CYC)) u_chk (.*);
